// >>> src/biphase_line_framer.sv
`timescale 1ns/1ns
`include "biphase_map.svh"

// ==========================================
// Word FIFO
module word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // Clock and control
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Full when indices match and wrap bits differ
  assign out_valid = wr_ptr != rd_ptr;
  assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Pointers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
      if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage
  always_ff @(posedge clock) begin
    if (ce && in_valid && in_ready) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : word_fifo

// ==========================================
// Line framer top
module biphase_line_framer #(
  parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
  // Clock and control
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  // Configuration
  input wire biphase_pkg::protocol_type protocol_select_field,
  input wire logic repeater_enable,
  input wire logic loopback,
  input wire logic rx_use_pin,
  input wire logic [2:0] mux_route,
  // Transmit words
  input wire biphase_pkg::tx_word_type tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  // Received words
  output biphase_pkg::rx_word_type rx_word,
  output logic rx_valid,
  // Line side
  input wire logic comparator_in,
  input wire logic serial_in,
  output logic tx_line,
  output logic tx_drive_enable,
  // Status and interrupts
  output logic tx_active,
  output logic rx_active,
  output logic irq_tx_empty,
  output logic irq_rx_data,
  output logic irq_rx_error
);
  import biphase_pkg::*;

  localparam logic [63:0] COAX_INC = ((`COAX_RATE_HZ * `TICKS_PER_BIT) << `ACC_SHIFT) / `CLOCK_HZ;
  localparam logic [63:0] TWIN_INC = ((`TWINAX_RATE_HZ * `TICKS_PER_BIT) << `ACC_SHIFT) / `CLOCK_HZ;
  localparam logic [63:0] GEN_INC = ((`GENERAL_RATE_HZ * `TICKS_PER_BIT) << `ACC_SHIFT) / `CLOCK_HZ;

  protocol_type proto;
  logic twin;
  logic [31:0] tick_acc;
  logic [31:0] tick_inc;
  logic [32:0] acc_sum;
  logic bit_tick;
  tx_word_type fifo_word;
  logic [$bits(tx_word_type)-1:0] fifo_raw;
  logic fifo_valid;
  logic fifo_pop;
  tx_state_type tx_st;
  tx_state_type next_st;
  logic [7:0] tx_cnt;
  logic [7:0] next_cnt;
  logic [2:0] tx_phase;
  logic [15:0] tx_frame;
  logic [15:0] frame_src;
  logic [4:0] tx_left;
  logic [4:0] frame_len;
  logic tx_cur_last;
  logic tx_addr_done;
  logic tx_second;
  logic tx_bit;
  logic next_bit;
  logic emit_viol;
  logic emit_hold;
  logic take_frame;
  logic use_addr;
  logic adv;
  logic next_first;
  logic next_second;
  logic [5:0] viol_sel;
  logic [8:0] gen_body;
  logic [10:0] coax_body;
  logic [11:0] twin_body;
  rx_state_type rx_st;
  logic rx_src;
  logic rx_lvl;
  logic rx_prev;
  logic rx_edge;
  logic rx_enabled;
  logic [4:0] rx_run;
  logic [4:0] rx_cnt;
  logic [4:0] rx_len;
  logic [15:0] rx_sreg;
  logic rx_first;
  logic rx_done;
  logic rx_fault;
  rx_word_type dec_word;

  // One selection drives both directions
  assign proto = protocol_select_field;
  assign twin = is_twinax(proto);

  // ==========================================
  // Bit tick generator
  always_comb begin
    if (twin) tick_inc = TWIN_INC[31:0];
    else if (is_general(proto)) tick_inc = GEN_INC[31:0];
    else tick_inc = COAX_INC[31:0];
    acc_sum = {1'b0, tick_acc} + {1'b0, tick_inc};
  end
  assign bit_tick = ce && acc_sum[32];

  // Fractional accumulator
  always_ff @(posedge clock) begin
    if (sys_rst) tick_acc <= 32'h0;
    else if (ce) tick_acc <= acc_sum[31:0];
  end

  // ==========================================
  // Transmit buffer
  word_fifo #(.WIDTH($bits(tx_word_type)), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_data(tx_word),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_raw),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  assign fifo_word = tx_word_type'(fifo_raw);

  // ==========================================
  // Frame builder
  always_comb begin
    use_addr = tx_address_first(proto) && !tx_addr_done;
    gen_body = {1'b1, reverse8(fifo_word.data)};
    coax_body = {1'b1, fifo_word.data, fifo_word.aux[1:0]};
    twin_body = {1'b1, reverse8(fifo_word.data), reverse3(fifo_word.aux)};
    if (use_addr) begin
      frame_src = {1'b1, mux_route, 3'h0, ^{1'b1, mux_route}, 8'h00};
      frame_len = `LEN_ADDR;
    end else if (twin) begin
      frame_src = {twin_body, ^twin_body, 3'h0};
      frame_len = `LEN_TWIN;
    end else if (is_general(proto)) begin
      frame_src = {gen_body, ^gen_body, 6'h00};
      frame_len = `LEN_GEN;
    end else begin
      frame_src = {coax_body, ^coax_body, 4'h0};
      frame_len = `LEN_COAX;
    end
  end

  // ==========================================
  // Next bit at each boundary
  always_comb begin
    next_st = tx_st;
    next_cnt = tx_cnt;
    next_bit = 1'b0;
    emit_viol = 1'b0;
    emit_hold = 1'b0;
    take_frame = 1'b0;
    unique case (tx_st)
      TX_IDLE: begin
        next_st = TX_QUIESCE;
        next_cnt = 8'h00;
        next_bit = 1'b1;
      end
      TX_QUIESCE: begin
        next_bit = 1'b1;
        next_cnt = tx_cnt + 8'h01;
        if (tx_cnt == `QUIESCE_LAST) begin
          next_st = TX_VIOL;
          next_cnt = 8'h00;
          emit_viol = 1'b1;
        end
      end
      TX_VIOL: begin
        if (tx_cnt == `VIOL_LAST) begin
          take_frame = 1'b1;
        end else begin
          next_cnt = tx_cnt + 8'h01;
          emit_viol = 1'b1;
        end
      end
      TX_FRAME: begin
        if (tx_left != 5'h01) begin
          next_bit = tx_frame[14];
        end else if (tx_cur_last) begin
          if (twin) next_st = TX_IDLE;
          else next_st = TX_END;
          next_cnt = 8'h00;
        end else if (fifo_valid) begin
          take_frame = 1'b1;
        end else begin
          next_st = twin ? TX_FILL : TX_END;
          next_cnt = 8'h00;
        end
      end
      TX_FILL: begin
        if (fifo_valid) begin
          take_frame = 1'b1;
        end else if (tx_cnt == `TWIN_FILL_MAX - 8'h01) begin
          next_st = TX_IDLE;
        end else begin
          next_cnt = tx_cnt + 8'h01;
        end
      end
      TX_END: begin
        if (tx_cnt == `END_HOLD_LAST) begin
          next_st = TX_IDLE;
        end else begin
          next_cnt = tx_cnt + 8'h01;
          emit_hold = 1'b1;
        end
      end
    endcase
    if (take_frame) begin
      next_st = TX_FRAME;
      next_bit = 1'b1;
    end
    viol_sel = `VIOL_PATTERN << {next_cnt[1:0], 1'b0};
    if (emit_viol) begin
      next_first = viol_sel[5];
      next_second = viol_sel[4];
    end else if (emit_hold) begin
      next_first = 1'b1;
      next_second = 1'b1;
    end else begin
      next_first = !next_bit;
      next_second = next_bit;
    end
  end

  assign adv = bit_tick && ((tx_st == TX_IDLE) ? fifo_valid : (tx_phase == `LAST_PHASE));
  assign fifo_pop = adv && take_frame && !use_addr;
  assign tx_active = tx_st != TX_IDLE;
  assign tx_drive_enable = tx_active && !loopback;

  // Sequencer state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_st <= TX_IDLE;
      tx_cnt <= 8'h00;
      tx_bit <= 1'b0;
      tx_addr_done <= 1'b0;
    end else if (ce && adv) begin
      tx_st <= next_st;
      tx_cnt <= next_cnt;
      tx_bit <= next_bit;
      if (take_frame && use_addr) tx_addr_done <= 1'b1;
      if (next_st == TX_IDLE) tx_addr_done <= 1'b0;
    end
  end

  // Tick phase within the bit-time
  always_ff @(posedge clock) begin
    if (sys_rst) tx_phase <= 3'h0;
    else if (adv && tx_st == TX_IDLE) tx_phase <= 3'h0;
    else if (bit_tick && tx_st != TX_IDLE) tx_phase <= tx_phase + 3'h1;
  end

  // Line level, mid-bit change four ticks in
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_line <= 1'b0;
      tx_second <= 1'b0;
    end else if (adv && next_st != TX_IDLE) begin
      tx_line <= next_first ^ twin;
      tx_second <= next_second ^ twin;
    end else if (bit_tick && tx_active && tx_phase == `MIDBIT_PHASE) begin
      tx_line <= tx_second;
    end
  end

  // Frame shift register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_frame <= 16'h0000;
      tx_left <= 5'h00;
      tx_cur_last <= 1'b0;
    end else if (ce && adv) begin
      if (take_frame) begin
        tx_frame <= frame_src;
        tx_left <= frame_len;
        tx_cur_last <= !use_addr && fifo_word.last;
      end else if (tx_st == TX_FRAME) begin
        tx_frame <= {tx_frame[14:0], 1'b0};
        tx_left <= tx_left - 5'h01;
      end
    end
  end

  // ==========================================
  // Receiver
  assign rx_src = loopback ? tx_line : (rx_use_pin ? serial_in : comparator_in);
  assign rx_lvl = rx_src ^ twin;
  assign rx_edge = rx_lvl != rx_prev;
  assign rx_enabled = repeater_enable || !tx_active;
  assign rx_active = rx_st == RX_BITS;
  assign rx_len = rx_first ? `LEN_ADDR : (twin ? `LEN_TWIN :
                  (is_general(proto) ? `LEN_GEN : `LEN_COAX));

  // Run-length bit recovery
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_st <= RX_HUNT;
      rx_prev <= 1'b0;
      rx_run <= 5'h00;
      rx_cnt <= 5'h00;
      rx_sreg <= 16'h0000;
      rx_first <= 1'b0;
      rx_done <= 1'b0;
      rx_fault <= 1'b0;
    end else if (ce) begin
      rx_done <= 1'b0;
      rx_fault <= 1'b0;
      if (!rx_enabled) begin
        rx_st <= RX_HUNT;
        rx_cnt <= 5'h00;
        rx_fault <= rx_st == RX_BITS;
      end else if (bit_tick) begin
        rx_prev <= rx_lvl;
        rx_run <= (rx_run == `RX_RUN_MAX) ? rx_run : rx_run + 5'h01;
        unique case (rx_st)
          RX_HUNT: begin
            if (rx_edge) begin
              rx_run <= 5'h00;
              // Idle longer than RX_LONG_MAX ticks is not a start
              if (rx_run >= `RX_LONG_RUN && rx_run <= `RX_LONG_MAX && rx_lvl) begin
                rx_st <= RX_BITS;
                rx_sreg <= 16'h0001;
                rx_cnt <= 5'h01;
                rx_first <= rx_address_first(proto);
              end
            end
          end
          RX_BITS: begin
            if (rx_edge && rx_run >= `RX_WINDOW) begin
              rx_run <= 5'h00;
              if (rx_cnt != 5'h00) begin
                rx_sreg <= {rx_sreg[14:0], rx_lvl};
                rx_cnt <= rx_cnt + 5'h01;
                if (rx_cnt + 5'h01 == rx_len) begin
                  rx_cnt <= 5'h00;
                  rx_done <= 1'b1;
                end
              end else if (rx_lvl) begin
                rx_sreg <= 16'h0001;
                rx_cnt <= 5'h01;
              end else if (!twin) begin
                rx_st <= RX_HUNT;
              end
            end else if (rx_run == `RX_TIMEOUT) begin
              rx_st <= RX_HUNT;
              rx_fault <= rx_cnt != 5'h00;
            end
          end
        endcase
      end
      if (rx_done) rx_first <= 1'b0;
    end
  end

  // Frame decode and parity check
  always_comb begin
    dec_word = '0;
    if (rx_first) begin
      dec_word.data = {2'h0, rx_sreg[6:1]};
      dec_word.aux = rx_sreg[6:4];
      dec_word.address_frame = 1'b1;
      dec_word.parity_error = ^rx_sreg[7:0];
    end else if (twin) begin
      dec_word.data = reverse8(rx_sreg[14:7]);
      dec_word.aux = reverse3(rx_sreg[6:4]);
      dec_word.parity_error = (^rx_sreg[15:3]) || (|rx_sreg[2:0]);
    end else if (is_general(proto)) begin
      dec_word.data = reverse8(rx_sreg[8:1]);
      dec_word.parity_error = ^rx_sreg[9:0];
    end else begin
      dec_word.data = rx_sreg[10:3];
      dec_word.aux = {1'b0, rx_sreg[2:1]};
      dec_word.parity_error = ^rx_sreg[11:0];
    end
  end

  // Word output and error pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_word <= '0;
      rx_valid <= 1'b0;
      irq_rx_error <= 1'b0;
    end else if (ce) begin
      rx_valid <= rx_done;
      irq_rx_error <= rx_fault || (rx_done && dec_word.parity_error);
      if (rx_done) rx_word <= dec_word;
    end
  end

  // Interrupt sources
  assign irq_tx_empty = !fifo_valid && !tx_active;
  assign irq_rx_data = rx_valid;

  // ==========================================
  // Checks
  a_midbit_toggle: assert property (@(posedge clock) disable iff (sys_rst)
    (tx_st == TX_FRAME && bit_tick && tx_phase == `MIDBIT_PHASE) |=> tx_line != $past(tx_line))
    else $error("no mid-bit transition");
  a_one_rises: assert property (@(posedge clock) disable iff (sys_rst)
    (tx_st == TX_FRAME && bit_tick && tx_phase == `MIDBIT_PHASE && !twin)
    |=> tx_line == $past(tx_bit))
    else $error("wrong mid-bit polarity");
  a_twin_inverted: assert property (@(posedge clock) disable iff (sys_rst)
    (tx_st == TX_FRAME && bit_tick && tx_phase == `MIDBIT_PHASE && twin)
    |=> tx_line != $past(tx_bit))
    else $error("twinax polarity not inverted");
  a_quiesce_five: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(tx_st == TX_VIOL) |-> $past(tx_st) == TX_QUIESCE && $past(tx_cnt) == `QUIESCE_LAST)
    else $error("quiesce count wrong");
  a_sync_first: assert property (@(posedge clock) disable iff (sys_rst)
    (adv && take_frame) |=> tx_bit && tx_st == TX_FRAME && tx_frame[15])
    else $error("frame without sync");
  a_fill_bound: assert property (@(posedge clock) disable iff (sys_rst)
    (tx_st == TX_FILL) |-> tx_cnt < `TWIN_FILL_MAX && twin)
    else $error("fill run too long");
  a_end_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (tx_st == TX_END && tx_cnt != 8'h00 && bit_tick) |=> $stable(tx_line))
    else $error("transition in end hold");
  a_twin_no_end: assert property (@(posedge clock) disable iff (sys_rst)
    ($fell(tx_active) && twin) |-> $past(tx_st) != TX_END)
    else $error("twinax sent end sequence");
  a_half_duplex: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && !repeater_enable && tx_active) |=> rx_st == RX_HUNT)
    else $error("receiver ran during transmit");
endmodule : biphase_line_framer

// >>> src/biphase_map.svh
`ifndef BIPHASE_MAP_SVH
`define BIPHASE_MAP_SVH
// ==========================================
// Clock and line rates
`define CLOCK_HZ 64'h5F5E100
`define COAX_RATE_HZ 64'h23FDAC
`define TWINAX_RATE_HZ 64'hF4240
`define GENERAL_RATE_HZ 64'h23FDAC
`define TICKS_PER_BIT 64'h8
`define ACC_SHIFT 64'h20
// ==========================================
// Bit-time phases
`define MIDBIT_PHASE 3'h3
`define LAST_PHASE 3'h7
// ==========================================
// Start and end sequences
`define QUIESCE_LAST 8'h04
`define VIOL_LAST 8'h02
`define VIOL_PATTERN 6'h38
`define END_HOLD_LAST 8'h02
`define TWIN_FILL_MAX 8'hF0
// ==========================================
// Frame lengths in bits
`define LEN_COAX 5'h0C
`define LEN_ADDR 5'h08
`define LEN_TWIN 5'h10
`define LEN_GEN 5'h0A
// ==========================================
// Receiver run-length limits in ticks
`define RX_LONG_RUN 5'h0A
`define RX_LONG_MAX 5'h14
`define RX_WINDOW 5'h06
`define RX_TIMEOUT 5'h0C
`define RX_RUN_MAX 5'h1F
// ==========================================
// Buffering
`define TX_FIFO_DEPTH 32
`endif

// >>> src/biphase_pkg.sv
package biphase_pkg;
  // ==========================================
  // Protocol select field codes
  typedef enum logic [2:0] {
    PROTO_COAX = 3'h0,
    PROTO_MUX_RX = 3'h1,
    PROTO_MUX_TX = 3'h2,
    PROTO_MUX_BOTH = 3'h3,
    PROTO_TWIN = 3'h4,
    PROTO_TWIN_ALL = 3'h5,
    PROTO_GEN = 3'h6,
    PROTO_GEN_ALL = 3'h7
  } protocol_type;
  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_QUIESCE = 3'h1,
    TX_VIOL = 3'h2,
    TX_FRAME = 3'h3,
    TX_FILL = 3'h4,
    TX_END = 3'h5
  } tx_state_type;
  typedef enum logic {
    RX_HUNT = 1'h0,
    RX_BITS = 1'h1
  } rx_state_type;
  // ==========================================
  // Word carriers
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] aux;
    logic last;
  } tx_word_type;
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] aux;
    logic address_frame;
    logic parity_error;
  } rx_word_type;
  // ==========================================
  // Protocol decoding helpers
  function automatic logic is_twinax(input protocol_type p);
    return p[2:1] == 2'h2;
  endfunction : is_twinax
  function automatic logic is_general(input protocol_type p);
    return p[2:1] == 2'h3;
  endfunction : is_general
  function automatic logic tx_address_first(input protocol_type p);
    return p == PROTO_MUX_TX || p == PROTO_MUX_BOTH;
  endfunction : tx_address_first
  function automatic logic rx_address_first(input protocol_type p);
    return p == PROTO_MUX_RX || p == PROTO_MUX_BOTH;
  endfunction : rx_address_first
  function automatic logic [7:0] reverse8(input logic [7:0] v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction : reverse8
  function automatic logic [2:0] reverse3(input logic [2:0] v);
    return {v[0], v[1], v[2]};
  endfunction : reverse3
endpackage : biphase_pkg

// >>> testbench/line_model.sv
`timescale 1ns/1ns
// ==========================================
// Line interface model
module line_model (
  // Clock and rate
  input wire logic clock,
  input wire logic twin,
  // Line
  input wire logic tx_line,
  input wire logic tx_active,
  output logic line_out
);
  real half_ns;
  logic cap_q[$];
  // Half bit time of the line rate
  always_comb half_ns = twin ? 500.0 : 211.98;
  initial line_out = 1'b0;
  // Sample each sent half bit at its centre
  always begin
    @(posedge tx_active);
    #(half_ns / 2);
    while (tx_active === 1'b1) begin
      cap_q.push_back(tx_line);
      #(half_ns);
    end
  end
  // Drive halves on clock edges; line then holds still
  task automatic send(input logic h[$]);
    realtime t0;
    t0 = $realtime;
    foreach (h[i]) begin
      while ($realtime < t0 + i * half_ns) @(posedge clock);
      line_out <= h[i];
    end
  endtask : send
endmodule : line_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
// ==========================================
// Bench top
module tb_top;
  import biphase_pkg::*;
  logic clock = 1'b0;
  logic sys_rst, ce, repeater_enable, loopback, rx_use_pin, tx_valid, twin, line;
  logic tx_ready, rx_valid, tx_line, tx_drive_enable, tx_active, rx_active;
  logic irq_tx_empty, irq_rx_error, irq_rx_data;
  logic [2:0] mux_route;
  protocol_type protocol_select_field;
  tx_word_type tx_word;
  rx_word_type rx_word;
  int bad_count, total_checks, cyc, err_n, dat_n;
  logic hq[$];
  logic [7:0] acc_q[$];
  rx_word_type rx_q[$];
  biphase_line_framer biphase_line_framer_i (.clock(clock), .sys_rst(sys_rst), .ce(ce),
    .protocol_select_field(protocol_select_field), .repeater_enable(repeater_enable),
    .loopback(loopback), .rx_use_pin(rx_use_pin), .mux_route(mux_route),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word),
    .rx_valid(rx_valid), .comparator_in(rx_use_pin ? 1'b0 : line),
    .serial_in(rx_use_pin ? line : 1'b0), .tx_line(tx_line),
    .tx_drive_enable(tx_drive_enable), .tx_active(tx_active), .rx_active(rx_active),
    .irq_tx_empty(irq_tx_empty), .irq_rx_data(irq_rx_data), .irq_rx_error(irq_rx_error));
  line_model line_model_i (.clock(clock), .twin(twin), .tx_line(tx_line),
    .tx_active(tx_active), .line_out(line));
  // Clock
  initial forever #5 clock = ~clock;
  // Received words, error pulses and run limit
  always @(posedge clock) begin
    cyc++;
    if (rx_valid === 1'b1) rx_q.push_back(rx_word);
    if (irq_rx_error === 1'b1) err_n++;
    if (irq_rx_data === 1'b1) dat_n++;
    if (cyc == 70000) begin
      bad_count++;
      finish_test();
    end
  end
  // Expected line halves
  task automatic add_bit(input logic b);
    hq.push_back(~(b ^ twin));
    hq.push_back(b ^ twin);
  endtask : add_bit
  task automatic add_frame(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) add_bit(v[i]);
  endtask : add_frame
  task automatic add_start;
    repeat (5) add_bit(1'b1);
    for (int i = 0; i < 6; i++) hq.push_back((i < 3) ^ twin);
  endtask : add_start
  task automatic add_end;
    add_bit(1'b0);
    repeat (4) hq.push_back(1'b1);
  endtask : add_end
  task automatic add_coax(input logic [7:0] d, input logic [1:0] c);
    add_frame({1'b1, d, c, ^{1'b1, d, c}}, 12);
  endtask : add_coax
  task automatic add_twin(input logic [7:0] d, input logic [2:0] a);
    logic [7:0] rd;
    logic [2:0] ra;
    rd = {<<{d}};
    ra = {<<{a}};
    add_frame({1'b1, rd, ra, ^{1'b1, d, a}, 3'h0}, 16);
  endtask : add_twin
  function automatic logic [11:0] rxp(input rx_word_type w);
    return {w.data, w.aux[1:0], w.address_frame, w.parity_error};
  endfunction : rxp
  // Bus-side helpers
  task automatic cfg(input protocol_type p, input logic r, input logic lb, input logic pin);
    protocol_select_field <= p;
    repeater_enable <= r;
    loopback <= lb;
    rx_use_pin <= pin;
    twin <= (p[2:1] == 2'h2);
    @(posedge clock);
    rx_q.delete();
    line_model_i.cap_q.delete();
    err_n = 0;
    dat_n = 0;
  endtask : cfg
  task automatic push(input logic [7:0] d, input logic [2:0] a, input logic l);
    tx_word <= '{data: d, aux: a, last: l};
    tx_valid <= 1'b1;
    @(posedge clock);
    while (tx_ready !== 1'b1) @(posedge clock);
  endtask : push
  task automatic check_tx(input string name);
    logic [127:0] e, g;
    e = '0;
    g = '0;
    wait (tx_active === 1'b1);
    wait (tx_active === 1'b0);
    repeat (120) @(posedge clock);
    foreach (hq[i]) e[i] = hq[i];
    foreach (line_model_i.cap_q[i]) if (i < 128) g[i] = line_model_i.cap_q[i];
    `CHK(name, e, g)
    `CHK("halves", hq.size(), line_model_i.cap_q.size())
    hq.delete();
  endtask : check_tx
  // ==========================================
  // Scenarios
  task automatic t_coax;
    cfg(PROTO_COAX, 1'b1, 1'b1, 1'b0);
    push(8'hA5, 3'h2, 1'b1);
    tx_valid <= 1'b0;
    add_start();
    add_coax(8'hA5, 2'h2);
    add_end();
    wait (tx_active === 1'b1);
    #1;
    `CHK("drive", 1'b0, tx_drive_enable)
    check_tx("coax");
    `CHK("loop word", 12'hA58, rxp(rx_q[0]))
    $display("test coax loopback done");
  endtask : t_coax
  task automatic t_twin;
    cfg(PROTO_TWIN, 1'b0, 1'b0, 1'b0);
    push(8'h3C, 3'h6, 1'b0);
    push(8'h81, 3'h1, 1'b1);
    tx_valid <= 1'b0;
    add_start();
    add_twin(8'h3C, 3'h6);
    add_twin(8'h81, 3'h1);
    check_tx("twinax");
    $display("test twinax done");
  endtask : t_twin
  task automatic t_mux;
    mux_route <= 3'h5;
    cfg(PROTO_MUX_TX, 1'b0, 1'b0, 1'b0);
    push(8'h5A, 3'h1, 1'b1);
    tx_valid <= 1'b0;
    add_start();
    add_frame({1'b1, 3'h5, 3'h0, ^{1'b1, 3'h5}}, 8);
    add_coax(8'h5A, 2'h1);
    add_end();
    check_tx("address");
    $display("test address frame done");
  endtask : t_mux
  task automatic t_gen;
    cfg(PROTO_GEN_ALL, 1'b0, 1'b0, 1'b0);
    push(8'h1E, 3'h0, 1'b1);
    tx_valid <= 1'b0;
    add_start();
    add_frame({1'b1, 8'h78, ^{1'b1, 8'h1E}}, 10);
    add_end();
    check_tx("general");
    $display("test general done");
  endtask : t_gen
  task automatic t_rx;
    cfg(PROTO_COAX, 1'b1, 1'b0, 1'b0);
    add_start();
    add_coax(8'h96, 2'h1);
    add_coax(8'h96, 2'h1);
    hq[$] = ~hq[$];
    hq[$-1] = ~hq[$-1];
    add_end();
    line_model_i.send(hq);
    hq.delete();
    repeat (100) @(posedge clock);
    `CHK("good word", 12'h964, rxp(rx_q[0]))
    `CHK("bad parity", 12'h965, rxp(rx_q[1]))
    `CHK("error pulses", 1, err_n)
    `CHK("data pulses", 2, dat_n)
    $display("test receive done");
  endtask : t_rx
  task automatic t_half;
    logic q[$];
    cfg(PROTO_COAX, 1'b0, 1'b0, 1'b1);
    add_start();
    repeat (4) add_coax(8'hF0, 2'h3);
    add_end();
    q = hq;
    hq.delete();
    fork
      line_model_i.send(q);
    join_none
    wait (rx_active === 1'b1);
    push(8'h11, 3'h0, 1'b1);
    tx_valid <= 1'b0;
    wait (tx_active === 1'b1);
    @(posedge clock);
    #1;
    `CHK("rx held", 1'b0, rx_active)
    `CHK("drive", 1'b1, tx_drive_enable)
    wait fork;
    wait (tx_active === 1'b0);
    `CHK("disable error", 1, err_n)
    $display("test half duplex done");
  endtask : t_half
  task automatic t_fill;
    cfg(PROTO_COAX, 1'b1, 1'b1, 1'b0);
    tx_valid <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      tx_word <= '{data: 8'h40 + i[7:0], aux: 3'h0, last: 1'b1};
      @(posedge clock);
      if (tx_ready === 1'b1) acc_q.push_back(tx_word.data);
    end
    tx_valid <= 1'b0;
    `CHK("full", 1'b0, tx_ready)
    `CHK("accepted", 1'b1, acc_q.size() >= 32 && acc_q.size() <= 33)
    while (rx_q.size() < acc_q.size()) @(posedge clock);
    foreach (acc_q[i]) `CHK("order", acc_q[i], rx_q[i].data)
    wait (tx_active === 1'b0);
    #1;
    `CHK("empty", 1'b1, irq_tx_empty)
    $display("test fifo done");
  endtask : t_fill
  // Verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    {sys_rst, ce, repeater_enable, loopback, rx_use_pin, tx_valid, twin} = 7'h60;
    mux_route = 3'h0;
    protocol_select_field = PROTO_COAX;
    tx_word = '0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_coax();
    t_twin();
    t_mux();
    t_gen();
    t_rx();
    t_half();
    t_fill();
    finish_test();
  end
endmodule : tb_top
